// *** rtl/aer_pkg.sv ***
package aer_pkg;
  localparam logic [15:0] EVT_REQ_ADDR = 16'h0220;
  localparam logic [15:0] EVT_MASK_ADDR = 16'h0204;
  localparam logic [31:0] EVT_MASK_RESET = 32'h00ff_ff0f;
  localparam logic [15:0] CTRL_ADDR = 16'h0120;
  localparam int CTRL_LANE = 1;
  localparam logic [15:0] LATCH_TIME_LO = 16'h09b0;
  localparam logic [15:0] LATCH_TIME_HI = 16'h09cc;
  localparam logic [15:0] SYNC_STAT_ADDR = 16'h098c;
  localparam int SYNC_PULSE_ZERO_LANE = 2;
  localparam int SYNC_PULSE_ONE_LANE = 3;
  localparam logic [8:0] BM_REGION = 9'h010;
  localparam int BM_ACT_LANE = 2;
  localparam logic [15:0] NV_CTRL_ADDR = 16'h0500;
  localparam int NV_CMD_LANE = 3;
  localparam logic [15:0] WD_STAT_ADDR = 16'h0440;
  localparam int WD_LANE = 0;
  localparam int EV_CTRL = 0;
  localparam int EV_LATCH = 1;
  localparam int EV_SYNC_PULSE_ZERO = 2;
  localparam int EV_SYNC_PULSE_ONE = 3;
  localparam int EV_BM = 4;
  localparam int EV_NV = 5;
  localparam int EV_WD = 6;
  localparam int EV_BITS = 7;
  localparam logic [6:0] EV_RESET = 7'h00;
endpackage : aer_pkg

// *** rtl/aer_collector.sv ***
`timescale 1ns/10ps
module aer_collector
  import aer_pkg::*;
#(
  parameter int DATA_W = 32
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Host interface register access, byte address of a 32-bit word.
  input wire logic [15:0] hif_addr,
  input wire logic [3:0] hif_be,
  input wire logic hif_rd,
  input wire logic hif_wr,
  input wire logic [DATA_W-1:0] hif_wdata,
  output logic [DATA_W-1:0] hif_rdata,
  output logic hif_rvalid,
  // Event sources.
  input wire logic ctrl_written,
  input wire logic latch_change,
  input wire logic latch_host_ctrl,
  input wire logic sync_pulse_zero,
  input wire logic sync_pulse_one,
  input wire logic sync_zero_map,
  input wire logic sync_one_map,
  input wire logic bm_act_change,
  input wire logic nv_cmd_request,
  input wire logic pd_wd_expired,
  // Request flags and host interrupt.
  output logic [EV_BITS-1:0] event_req,
  output logic host_irq
);

  if (DATA_W != 32) begin : g_bad_width
    $error("aer_collector serves a 32-bit data path only.");
  end

  typedef struct packed {
    logic [EV_BITS-1:0] ev;
    logic [31:0] mask;
    logic [31:0] rdata;
    logic rvalid;
    logic irq;
  } aer_state_t;

  aer_state_t s_q;
  aer_state_t s_d;
  logic [15:0] waddr;
  logic [EV_BITS-1:0] set_ev;
  logic [EV_BITS-1:0] clr_ev;
  logic [31:0] req_word;
  logic [EV_BITS-1:0] ev_next;

  assign waddr = {hif_addr[15:2], 2'b00};

  always_comb begin
    set_ev = '0;
    clr_ev = '0;
    set_ev[EV_CTRL] = ctrl_written;
    // A latch unit under network control never reports here.
    set_ev[EV_LATCH] = latch_change & latch_host_ctrl;
    set_ev[EV_SYNC_PULSE_ZERO] = sync_pulse_zero & sync_zero_map;
    set_ev[EV_SYNC_PULSE_ONE] = sync_pulse_one & sync_one_map;
    set_ev[EV_BM] = bm_act_change;
    set_ev[EV_NV] = nv_cmd_request;
    set_ev[EV_WD] = pd_wd_expired;
    clr_ev[EV_CTRL] = hif_rd && waddr == CTRL_ADDR && hif_be[CTRL_LANE];
    clr_ev[EV_LATCH] = hif_rd && waddr >= LATCH_TIME_LO
                       && waddr <= LATCH_TIME_HI;
    clr_ev[EV_SYNC_PULSE_ZERO] = hif_rd && waddr == SYNC_STAT_ADDR
                       && hif_be[SYNC_PULSE_ZERO_LANE];
    clr_ev[EV_SYNC_PULSE_ONE] = hif_rd && waddr == SYNC_STAT_ADDR
                       && hif_be[SYNC_PULSE_ONE_LANE];
    // Each channel keeps its activation byte at offset 6 of an eight-byte
    // slot, so one decode of the region and address bit 2 covers them all.
    clr_ev[EV_BM] = hif_rd && hif_addr[15:7] == BM_REGION && hif_addr[2]
                    && hif_be[BM_ACT_LANE];
    clr_ev[EV_NV] = hif_wr && waddr == NV_CTRL_ADDR
                    && hif_be[NV_CMD_LANE];
    clr_ev[EV_WD] = hif_rd && waddr == WD_STAT_ADDR && hif_be[WD_LANE];
  end

  // Set wins over clear so an event landing on the clearing read survives.
  // Writes to the request word are not decoded at all.
  assign ev_next = (s_q.ev & ~clr_ev) | set_ev;
  assign req_word = {{(32-EV_BITS){1'b0}}, s_q.ev};

  always_comb begin
    s_d = s_q;
    s_d.ev = ev_next;
    s_d.rvalid = hif_rd;
    // Apart from bit 5 of the request word, which a write to NV_CTRL_ADDR clears, the mask is the only word a host write may change.
    if (hif_wr && waddr == EVT_MASK_ADDR) begin
      for (int b = 0; b < 4; b++) begin
        if (hif_be[b]) begin
          s_d.mask[8*b +: 8] = hif_wdata[8*b +: 8];
        end
      end
    end
    // Read data holds between reads, so a slow host may still pick it up
    // after the valid pulse has gone.
    if (hif_rd) begin
      if (waddr == EVT_REQ_ADDR) begin
        s_d.rdata = req_word;
      end else if (waddr == EVT_MASK_ADDR) begin
        s_d.rdata = s_q.mask;
      end else begin
        s_d.rdata = '0;
      end
    end
    // The interrupt follows the flags that will stand next cycle.
    s_d.irq = |({{(32-EV_BITS){1'b0}}, ev_next} & s_d.mask);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_q.ev <= EV_RESET;
      s_q.mask <= EVT_MASK_RESET;
      s_q.rdata <= '0;
      s_q.rvalid <= 1'b0;
      s_q.irq <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign hif_rdata = s_q.rdata;
  assign hif_rvalid = s_q.rvalid;
  assign event_req = s_q.ev;
  assign host_irq = s_q.irq;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Setting and clearing of the event bits that readers clear.
  a_ctrl_set: assert property (ctrl_written |=> event_req[EV_CTRL])
    else $error("control write did not set bit 0");
  a_ctrl_clr: assert property (
    hif_rd && waddr == CTRL_ADDR && hif_be[CTRL_LANE] && !ctrl_written
    |=> !event_req[EV_CTRL])
    else $error("control read did not clear bit 0");
  a_latch_gate: assert property (
    !$past(event_req[EV_LATCH]) && event_req[EV_LATCH]
    |-> $past(latch_host_ctrl) && $past(latch_change))
    else $error("latch bit set without host-controlled change");
  a_latch_clr: assert property (
    hif_rd && waddr == LATCH_TIME_LO && !latch_change
    |=> !event_req[EV_LATCH])
    else $error("latch time read did not clear bit 1");
  a_latch_owner: assert property (
    latch_change && !latch_host_ctrl && !event_req[EV_LATCH]
    |=> !event_req[EV_LATCH])
    else $error("latch bit set under network control");
  a_sync_pulse_zero_map: assert property (
    sync_pulse_zero && sync_zero_map |=> event_req[EV_SYNC_PULSE_ZERO])
    else $error("mapped sync zero not reflected");
  a_sync_pulse_zero_clr: assert property (
    hif_rd && waddr == SYNC_STAT_ADDR && hif_be[SYNC_PULSE_ZERO_LANE]
    && !(sync_pulse_zero && sync_zero_map) |=> !event_req[EV_SYNC_PULSE_ZERO])
    else $error("sync zero read did not clear bit 2");
  a_sync_pulse_one_map: assert property (
    sync_pulse_one && sync_one_map |=> event_req[EV_SYNC_PULSE_ONE])
    else $error("mapped sync one not reflected");
  a_sync_pulse_one_gate: assert property (
    !sync_one_map && !event_req[EV_SYNC_PULSE_ONE] |=> !event_req[EV_SYNC_PULSE_ONE])
    else $error("unmapped sync one set bit 3");
  a_sync_pulse_one_clr: assert property (
    hif_rd && waddr == SYNC_STAT_ADDR && hif_be[SYNC_PULSE_ONE_LANE]
    && !(sync_pulse_one && sync_one_map) |=> !event_req[EV_SYNC_PULSE_ONE])
    else $error("sync one read did not clear bit 3");
  a_bm_hold: assert property (
    bm_act_change ##1 !hif_rd [*2] |-> event_req[EV_BM])
    else $error("activation change lost");
  a_bm_clr: assert property (
    hif_rd && waddr == {BM_REGION, 7'h04} && hif_be[BM_ACT_LANE]
    && !bm_act_change |=> !event_req[EV_BM])
    else $error("activation read did not clear bit 4");

  // Bits 5 and 6 stand until their own clearing access.
  a_nv_flag: assert property (
    nv_cmd_request |=> event_req[EV_NV])
    else $error("emulation command not flagged");
  a_nv_clr: assert property (
    hif_wr && waddr == NV_CTRL_ADDR && hif_be[NV_CMD_LANE]
    && !nv_cmd_request |=> !event_req[EV_NV])
    else $error("command acknowledge did not clear bit 5");
  a_wd_flag: assert property (
    pd_wd_expired |=> event_req[EV_WD] ##1 (event_req[EV_WD]
    || $past(hif_rd)))
    else $error("watchdog flag dropped without a read");
  a_wd_clr: assert property (
    hif_rd && waddr == WD_STAT_ADDR && hif_be[WD_LANE]
    && !pd_wd_expired |=> !event_req[EV_WD])
    else $error("watchdog status read did not clear bit 6");

  // The interrupt and the mask that steers it.
  a_irq_mask: assert property (
    host_irq |-> |({{(32-EV_BITS){1'b0}}, event_req} & s_q.mask))
    else $error("interrupt without an unmasked request");
  a_irq_follow: assert property (
    |({{(32-EV_BITS){1'b0}}, event_req} & s_q.mask) |-> host_irq)
    else $error("unmasked request without an interrupt");
  a_mask_only: assert property (
    hif_wr && waddr != EVT_MASK_ADDR |=> s_q.mask == $past(s_q.mask))
    else $error("mask changed by a write to another word");

  // The read path of the host interface and the read-only request word.
  a_rvalid_pulse: assert property (hif_rd |=> hif_rvalid)
    else $error("read not answered with valid");
  a_rvalid_idle: assert property (!hif_rd |=> !hif_rvalid)
    else $error("valid without a read");
  a_rdata_req: assert property (
    hif_rd && waddr == EVT_REQ_ADDR |=> hif_rdata ==
    {{(DATA_W-EV_BITS){1'b0}}, $past(event_req)})
    else $error("request word read returned wrong flags");
  a_ro_write: assert property (
    hif_wr && !hif_rd && set_ev == '0 |=> event_req == $past(event_req)
    || $past(clr_ev[EV_NV]))
    else $error("write changed request flags");

  // Reset leaves every flag and the interrupt low.
  a_reset_zero: assert property (
    @(posedge sys_clk) disable iff (1'b0)
    $past(sys_rst) |-> event_req == EV_RESET && !host_irq)
    else $error("flags not zero after reset");

endmodule : aer_collector

// *** testbench/aer_host.sv ***
`timescale 1ns/10ps
module aer_host (
  // Clock and read answer.
  input wire logic sys_clk,
  input wire logic [31:0] hif_rdata,
  input wire logic hif_rvalid,
  // Bus request.
  output logic [15:0] hif_addr,
  output logic [3:0] hif_be,
  output logic hif_rd,
  output logic hif_wr,
  output logic [31:0] hif_wdata
);
  logic [31:0] rd_q;
  initial begin
    hif_addr = 16'h0000;
    hif_be = 4'h0;
    hif_rd = 1'b0;
    hif_wr = 1'b0;
    hif_wdata = 32'hffff_ffff;
  end
  // Sync flags are only trusted in acknowledge mode, so every read is a
  // plain single access with no retry.
  task access(input logic wr, input logic [15:0] a, input logic [3:0] b);
    @(negedge sys_clk);
    hif_addr = a;
    hif_be = b;
    hif_rd = !wr;
    hif_wr = wr;
    @(negedge sys_clk);
    hif_rd = 1'b0;
    hif_wr = 1'b0;
    // Released address and byte-enable lines show the inverse so stale values cannot pass.
    hif_addr = ~a;
    hif_be = ~b;
    rd_q = hif_rdata;
  endtask : access
endmodule : aer_host

// *** testbench/tb.sv ***
`timescale 1ns/10ps
module tb;
  import aer_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [6:0] src = 7'h00;
  logic latch_host_ctrl = 1'b0;
  logic sync_zero_map = 1'b0;
  logic sync_one_map = 1'b0;
  logic [15:0] hif_addr;
  logic [3:0] hif_be;
  logic hif_rd;
  logic hif_wr;
  logic [31:0] hif_wdata;
  logic [31:0] hif_rdata;
  logic hif_rvalid;
  logic [6:0] event_req;
  logic host_irq;
  int err_total = 0;
  int checks = 0;
  logic [15:0] clr_addr [7] = '{16'h0120, 16'h09b0, 16'h098c, 16'h098c,
                                16'h0806, 16'h0500, 16'h0440};
  logic [3:0] clr_be [7] = '{4'h2, 4'h1, 4'h4, 4'h8, 4'h4, 4'h8, 4'h1};
  always #10 sys_clk = ~sys_clk;
  aer_host u_host (.sys_clk(sys_clk), .hif_rdata(hif_rdata),
    .hif_rvalid(hif_rvalid), .hif_addr(hif_addr), .hif_be(hif_be),
    .hif_rd(hif_rd), .hif_wr(hif_wr), .hif_wdata(hif_wdata));
  aer_collector #(.DATA_W(32)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .hif_addr(hif_addr), .hif_be(hif_be), .hif_rd(hif_rd),
    .hif_wr(hif_wr), .hif_wdata(hif_wdata), .hif_rdata(hif_rdata),
    .hif_rvalid(hif_rvalid), .ctrl_written(src[0]),
    .latch_change(src[1]), .latch_host_ctrl(latch_host_ctrl),
    .sync_pulse_zero(src[2]), .sync_pulse_one(src[3]),
    .sync_zero_map(sync_zero_map), .sync_one_map(sync_one_map),
    .bm_act_change(src[4]), .nv_cmd_request(src[5]),
    .pd_wd_expired(src[6]), .event_req(event_req), .host_irq(host_irq));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task stop_test;
    $display("mismatches %0d comparisons %0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  // One-cycle source pulse; flags are visible at the return point.
  task fire(input logic [6:0] v);
    @(negedge sys_clk);
    src = v;
    @(negedge sys_clk);
    src = 7'h00;
  endtask : fire
  initial begin
    #100us;
    err_total++;
    stop_test;
  end
  initial begin
    repeat (8) @(negedge sys_clk);
    sys_rst = 1'b0;
    check(event_req, 32'h0);
    u_host.access(1'b0, EVT_REQ_ADDR, 4'hf);
    check(u_host.rd_q, 32'h0);
    check(hif_rvalid, 32'h1);
    // Unmapped sync pulses and a network-owned latch must stay silent.
    fire(7'h0e);
    check(event_req, 32'h0);
    latch_host_ctrl = 1'b1;
    sync_zero_map = 1'b1;
    sync_one_map = 1'b1;
    for (int i = 0; i < EV_BITS; i++) begin
      fire(7'h01 << i);
      check(event_req, 32'h1 << i);
      check(host_irq, EVT_MASK_RESET[i]);
      u_host.access(1'b1, EVT_REQ_ADDR, 4'hf);
      check(hif_rvalid, 32'h0);
      u_host.access(1'b0, EVT_REQ_ADDR, 4'hf);
      check(u_host.rd_q, 32'h1 << i);
      u_host.access(i == EV_NV, clr_addr[i], clr_be[i]);
      check(event_req, 32'h0);
    end
    // Opening the low mask byte lets the activation and watchdog bits raise the line.
    u_host.access(1'b1, EVT_MASK_ADDR, 4'h1);
    u_host.access(1'b0, EVT_MASK_ADDR, 4'hf);
    check(u_host.rd_q, EVT_MASK_RESET | 32'h0000_00ff);
    fire(7'h50);
    check(host_irq, 32'h1);
    // An expiry on the clearing read itself must survive the read.
    fork
      fire(7'h40);
      u_host.access(1'b0, WD_STAT_ADDR, 4'h1);
    join
    check(event_req, 32'h50);
    // A reset in mid-run drops every flag and restores the mask.
    sys_rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    check(event_req, 32'h0);
    check(host_irq, 32'h0);
    u_host.access(1'b0, EVT_MASK_ADDR, 4'hf);
    check(u_host.rd_q, EVT_MASK_RESET);
    stop_test;
  end
endmodule : tb
